/* verilog/nsc_host.sv */
// Host controller issuing status, protection, reset, powerdown and
// parameter page commands to an asynchronous NAND device.
// Assumes a classic Wishbone master and synchronous pin inputs.
//
// The register addresses and the Wishbone slave port were decided locally.
`default_nettype none

module nsc_host #(
  parameter int unsigned RDP_CYC = nsc_pkg::NSC_RDP_CYC,
  parameter int unsigned BUF_AW  = 8
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // Wishbone slave
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // NAND link
  output logic             ce_n,
  output logic             cle,
  output logic             ale,
  output logic             we_n,
  output logic             re_n,
  output logic             wp_n,
  output logic      [7:0]  io_out,
  output logic             io_oe_n,
  input  wire logic [7:0]  io_in,
  input  wire logic        rb_n
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD1, ST_ADDR, ST_CMD2, ST_WAIT, ST_POLLC,
    ST_POLLR, ST_CMD3, ST_READ, ST_WAKE, ST_RECOV
  } nsc_state_t;

  // -----------------------------------------------------------------
  // Decoding functions
  // -----------------------------------------------------------------
  // First command byte of each operation
  function automatic logic [7:0] cmd1_of(input logic [2:0] op);
    unique case (op)
      nsc_pkg::NSC_OP_ESTAT: cmd1_of = nsc_pkg::NSC_CMD_ESTAT;
      nsc_pkg::NSC_OP_PROT:  cmd1_of = nsc_pkg::NSC_CMD_PROT;
      nsc_pkg::NSC_OP_RESET: cmd1_of = nsc_pkg::NSC_CMD_RESET;
      nsc_pkg::NSC_OP_DPD:   cmd1_of = nsc_pkg::NSC_CMD_DPD;
      nsc_pkg::NSC_OP_PARAM: cmd1_of = nsc_pkg::NSC_CMD_PARAM;
      default:               cmd1_of = nsc_pkg::NSC_CMD_RND1;
    endcase
  endfunction

  // Number of address cycles per operation and density
  function automatic logic [1:0] nadr_of(input logic [2:0] op,
                                         input logic [1:0] den);
    unique case (op)
      nsc_pkg::NSC_OP_ESTAT: nadr_of = 2'h3;
      nsc_pkg::NSC_OP_PROT:
        nadr_of = (den == nsc_pkg::NSC_DEN_1G) ? 2'h2 : 2'h3;
      nsc_pkg::NSC_OP_PARAM: nadr_of = 2'h1;
      nsc_pkg::NSC_OP_RND:   nadr_of = 2'h2;
      default:               nadr_of = 2'h0;
    endcase
  endfunction

  // Address byte number idx; row[i] stands for address bit A(12+i), or column bit A(i) for the random read
  function automatic logic [7:0] adr_of(input logic [2:0]  op,
                                        input logic [1:0]  den,
                                        input logic [17:0] row,
                                        input logic [1:0]  idx);
    logic big;
    big = (den == nsc_pkg::NSC_DEN_4G);
    unique case (op)
      nsc_pkg::NSC_OP_PROT: begin
        if (idx == 2'h0) begin
          adr_of = big ? {row[8:7], 6'h00} : {row[7:6], 6'h00};
        end else if (idx == 2'h1) begin
          adr_of = big ? row[16:9] : row[15:8];
        end else begin
          adr_of = {7'h00, big ? row[17] : row[16]};
        end
      end
      nsc_pkg::NSC_OP_PARAM: adr_of = nsc_pkg::NSC_PARAM_ADR;
      nsc_pkg::NSC_OP_RND:
        adr_of = (idx == 2'h0) ? row[7:0] : {4'h0, row[11:8]};
      default: begin
        if (idx == 2'h0) begin
          adr_of = row[7:0];
        end else if (idx == 2'h1) begin
          adr_of = row[15:8];
        end else begin
          adr_of = {6'h00, row[17:16]};
        end
      end
    endcase
  endfunction

  // Byte mask from Wishbone lane selects
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  nsc_state_t  state_q, state_d;
  logic [2:0]  op_q;
  logic [1:0]  ph_q;
  logic [7:0]  div_q;
  logic [15:0] cnt_q;
  logic [1:0]  aidx_q;
  logic [8:0]  rcnt_q;
  logic [7:0]  bidx_q;
  logic [15:0] ctrl_q;
  logic [17:0] row_q;
  logic [7:0]  sb_q;
  logic [31:0] pg_q;
  logic        dpd_q, param_q, refused_q, spseen_q;
  logic        ack_q, wt_q;
  logic [31:0] dat_q;
  logic [7:0]  buf_rd;

  // -----------------------------------------------------------------
  // Decode of link activity
  // -----------------------------------------------------------------
  wire logic [1:0] den     = ctrl_q[nsc_pkg::NSC_CTRL_DEN +: 2];
  wire logic [7:0] len     = ctrl_q[nsc_pkg::NSC_CTRL_LEN +: 8];
  wire logic       ena     = (div_q == 8'(nsc_pkg::NSC_STB_CYC - 1));
  wire logic       bus_cmd = (state_q == ST_CMD1) || (state_q == ST_CMD2)
                          || (state_q == ST_POLLC) || (state_q == ST_CMD3);
  wire logic       bus_adr = (state_q == ST_ADDR);
  wire logic       bus_rd  = (state_q == ST_POLLR) || (state_q == ST_READ);
  wire logic       bus_any = bus_cmd || bus_adr || bus_rd;
  wire logic       done    = ena && bus_any && (ph_q == 2'h2);
  wire logic [1:0] nadr    = nadr_of(op_q, den);
  wire logic [7:0] abyte   = adr_of(op_q, den, row_q, aidx_q);
  wire logic       one_rd  = (op_q == nsc_pkg::NSC_OP_ESTAT)
                          || (op_q == nsc_pkg::NSC_OP_PROT);
  wire logic [8:0] nrd     = one_rd ? 9'h001
                           : ((len == 8'h00) ? 9'h100 : {1'b0, len});
  wire logic       last_rd = (rcnt_q == nrd - 9'h001);
  wire logic       need_rb = (op_q == nsc_pkg::NSC_OP_RESET)
                          || (op_q == nsc_pkg::NSC_OP_PARAM);
  wire logic       wait_end = (cnt_q >= 16'(nsc_pkg::NSC_WB_CYC - 1))
                           && (!need_rb || rb_n);
  wire logic       rdp_end = (cnt_q == 16'(RDP_CYC - 1));
  wire logic       buf_we  = done && (state_q == ST_READ) && !one_rd;
  wire logic [7:0] cbyte   = (state_q == ST_CMD1)  ? cmd1_of(op_q)
                           : (state_q == ST_CMD2)  ? nsc_pkg::NSC_CMD_RND2
                           : (state_q == ST_POLLC) ? nsc_pkg::NSC_CMD_STATUS
                           : nsc_pkg::NSC_CMD_READ;

  // -----------------------------------------------------------------
  // Decode of register access
  // -----------------------------------------------------------------
  wire logic        req     = wb_cyc_i && wb_stb_i;
  wire logic        wr_take = req && wb_we_i && ack_q;
  wire logic [31:0] wmask   = lane_mask(wb_sel_i);
  wire logic        hit_ctl = (wb_adr_i == nsc_pkg::NSC_REG_CTRL);
  wire logic        hit_row = (wb_adr_i == nsc_pkg::NSC_REG_ROW);
  wire logic        hit_st  = (wb_adr_i == nsc_pkg::NSC_REG_STAT);
  wire logic        hit_buf = (wb_adr_i[11:10] == nsc_pkg::NSC_BUF_SEL);
  wire logic        start_w = wr_take && hit_ctl && wb_sel_i[0]
                           && wb_dat_i[nsc_pkg::NSC_CTRL_START];
  wire logic [2:0]  op_w    = wb_dat_i[2:0];
  wire logic        otp_w   = wb_dat_i[nsc_pkg::NSC_CTRL_OTP];
  // Any start while busy is refused, a reset among them
  wire logic        start_ok = start_w && (state_q == ST_IDLE)
    && (op_w <= nsc_pkg::NSC_OP_RND)
    && (dpd_q ? (op_w == nsc_pkg::NSC_OP_WAKE)
              : (op_w != nsc_pkg::NSC_OP_WAKE))
    && !((op_w == nsc_pkg::NSC_OP_ESTAT) && otp_w)
    && !((op_w == nsc_pkg::NSC_OP_RND) && !param_q);
  wire logic [1:0]  pb_sp   = sb_q[1:0];
  wire logic [31:0] stat_w  = {22'h0,
    sb_q[nsc_pkg::NSC_SB_FAIL0] | sb_q[nsc_pkg::NSC_SB_FAIL1],
    (den == nsc_pkg::NSC_DEN_1G) && (pg_q == nsc_pkg::NSC_PG_1G),
    spseen_q,
    (pb_sp == nsc_pkg::NSC_PB_SOLID) || (pb_sp == nsc_pkg::NSC_PB_OPEN),
    pb_sp == nsc_pkg::NSC_PB_SOLID,
    sb_q[nsc_pkg::NSC_PB_UNPROT],
    param_q, dpd_q, refused_q, state_q != ST_IDLE};
  wire logic [31:0] rd_mux  = hit_buf ? {24'h0, buf_rd}
    : hit_ctl ? {16'h0, ctrl_q}
    : hit_row ? {14'h0, row_q}
    : hit_st  ? stat_w
    : (wb_adr_i == nsc_pkg::NSC_REG_RES)  ? {24'h0, sb_q}
    : (wb_adr_i == nsc_pkg::NSC_REG_PGSZ) ? pg_q
    : 32'h0;

  // -----------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------
  // Next state of the command sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
        if (start_ok) begin
          state_d = (op_w == nsc_pkg::NSC_OP_WAKE) ? ST_WAKE : ST_CMD1;
        end
      ST_CMD1:
        if (done) begin
          if (nadr != 2'h0) begin
            state_d = ST_ADDR;
          end else if (op_q == nsc_pkg::NSC_OP_DPD) begin
            state_d = ST_IDLE;
          end else begin
            state_d = ST_WAIT;
          end
        end
      ST_ADDR:
        if (done && (aidx_q == nadr - 2'h1)) begin
          state_d = (op_q == nsc_pkg::NSC_OP_RND) ? ST_CMD2 : ST_WAIT;
        end
      ST_CMD2:  if (done) state_d = ST_WAIT;
      ST_WAIT:
        if (wait_end) begin
          if (op_q == nsc_pkg::NSC_OP_PARAM) begin
            state_d = ST_POLLC;
          end else if (op_q == nsc_pkg::NSC_OP_RESET) begin
            state_d = ST_IDLE;
          end else begin
            state_d = ST_READ;
          end
        end
      ST_POLLC: if (done) state_d = ST_POLLR;
      ST_POLLR:
        if (done && io_in[nsc_pkg::NSC_SB_RDY]) state_d = ST_CMD3;
      ST_CMD3:  if (done) state_d = ST_READ;
      ST_READ:  if (done && last_rd) state_d = ST_IDLE;
      ST_WAKE:  if (ena) state_d = ST_RECOV;
      ST_RECOV: if (rdp_end) state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  // State, strobe divider and phase within a link cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      div_q   <= 8'h00;
      ph_q    <= 2'h0;
    end else begin
      state_q <= state_d;
      div_q   <= ena ? 8'h00 : div_q + 8'h01;
      ph_q    <= !bus_any ? 2'h0 : !ena ? ph_q
               : (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
    end
  end

  // Counters for address cycles, reads, waits and buffer index
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aidx_q <= 2'h0;
      rcnt_q <= 9'h000;
      cnt_q  <= 16'h0000;
      bidx_q <= 8'h00;
    end else begin
      aidx_q <= !bus_adr ? 2'h0 : done ? aidx_q + 2'h1 : aidx_q;
      rcnt_q <= (state_q != ST_READ) ? 9'h000
              : done ? rcnt_q + 9'h001 : rcnt_q;
      cnt_q  <= ((state_q == ST_WAIT) || (state_q == ST_RECOV))
              ? cnt_q + 16'h0001 : 16'h0000;
      if (start_ok) begin
        bidx_q <= (op_w == nsc_pkg::NSC_OP_RND) ? row_q[7:0] : 8'h00;
      end else if (buf_we) begin
        bidx_q <= bidx_q + 8'h01;
      end
    end
  end

  // -----------------------------------------------------------------
  // Link pins
  // -----------------------------------------------------------------
  // Latches set up in phase 0, strobe low in phase 1, rise in phase 2
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ce_n    <= 1'b1;
      cle     <= 1'b0;
      ale     <= 1'b0;
      we_n    <= 1'b1;
      re_n    <= 1'b1;
      io_out  <= 8'h00;
      io_oe_n <= 1'b1;
    end else if (ena) begin
      ce_n    <= (state_q == ST_IDLE) || (state_q == ST_RECOV);
      cle     <= bus_cmd;
      ale     <= bus_adr;
      we_n    <= !((bus_cmd || bus_adr) && (ph_q == 2'h1));
      re_n    <= !(bus_rd && (ph_q == 2'h1));
      io_out  <= bus_adr ? abyte : cbyte;
      io_oe_n <= !(bus_cmd || bus_adr);
    end
  end

  // -----------------------------------------------------------------
  // Operation flags and captured results
  // -----------------------------------------------------------------
  // Mode flags of the device as seen from here
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      op_q      <= nsc_pkg::NSC_OP_ESTAT;
      dpd_q     <= 1'b0;
      param_q   <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      if (start_ok) op_q <= op_w;
      if (done && (state_q == ST_CMD1) && (op_q == nsc_pkg::NSC_OP_DPD)) begin
        dpd_q <= 1'b1;
      end else if ((state_q == ST_RECOV) && rdp_end) begin
        dpd_q <= 1'b0;
      end
      if (done && (state_q == ST_CMD1)
          && (op_q == nsc_pkg::NSC_OP_PARAM)) begin
        param_q <= 1'b1;
      end else if (start_ok && (op_w != nsc_pkg::NSC_OP_RND)) begin
        param_q <= 1'b0;
      end
      if (start_w && !start_ok) begin
        refused_q <= 1'b1;
      end else if (wr_take && hit_st && wb_sel_i[0]
                   && wb_dat_i[nsc_pkg::NSC_ST_REFUSE]) begin
        refused_q <= 1'b0;
      end
    end
  end

  // Status byte, solid protection memory and page size word
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sb_q     <= 8'h00;
      spseen_q <= 1'b0;
      pg_q     <= 32'h0;
    end else begin
      if (done && (state_q == ST_READ) && one_rd) begin
        sb_q <= io_in;
      end
      if (done && (state_q == ST_READ) && (op_q == nsc_pkg::NSC_OP_PROT)
          && (io_in[1:0] == nsc_pkg::NSC_PB_SOLID)) begin
        spseen_q <= 1'b1;
      end
      if (buf_we && (op_q == nsc_pkg::NSC_OP_PARAM)
          && (bidx_q[7:2] == nsc_pkg::NSC_PG_WORD)) begin
        pg_q[{bidx_q[1:0], 3'b000} +: 8] <= io_in;
      end
    end
  end

  // -----------------------------------------------------------------
  // Register bus
  // -----------------------------------------------------------------
  // Two-cycle answer, write takes effect at the acknowledged edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wt_q   <= 1'b0;
      ack_q  <= 1'b0;
      dat_q  <= 32'h0;
      ctrl_q <= nsc_pkg::NSC_CTRL_RST;
      row_q  <= 18'h0;
    end else begin
      wt_q  <= req && !wt_q && !ack_q;
      ack_q <= req && wt_q && !ack_q;
      if (req && wt_q && !ack_q) dat_q <= rd_mux;
      if (wr_take && hit_ctl) begin
        ctrl_q <= ((ctrl_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]))
                & ~(16'h0001 << nsc_pkg::NSC_CTRL_START);
      end
      if (wr_take && hit_row) begin
        row_q <= (row_q & ~wmask[17:0]) | (wb_dat_i[17:0] & wmask[17:0]);
      end
    end
  end

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
  assign wp_n     = ctrl_q[nsc_pkg::NSC_CTRL_WP];

  // Buffer of parameter bytes, one 256-byte copy
  nsc_pbuf #(
    .AW (BUF_AW),
    .DW (8)
  ) u_pbuf (
    .clk_sys (clk_sys),
    .wr_en   (buf_we),
    .wr_addr (bidx_q[BUF_AW-1:0]),
    .wr_data (io_in),
    .rd_addr (wb_adr_i[BUF_AW+1:2]),
    .rd_data (buf_rd)
  );

endmodule

`default_nettype wire

/* common/nsc_pkg.sv */
// Constants shared by the NAND status and parameter host controller.
// Assumes a 50 MHz system clock and a byte-wide asynchronous NAND link.
`default_nettype none

package nsc_pkg;

  // ---------------------------------------------------------------
  // Clock and link timing
  // ---------------------------------------------------------------
  localparam int unsigned NSC_CLK_MHZ = 50;
  localparam int unsigned NSC_STB_NS  = 40;     // One strobe phase
  localparam int unsigned NSC_STB_CYC =
    (NSC_STB_NS * NSC_CLK_MHZ + 999) / 1000;
  localparam int unsigned NSC_WB_NS   = 100;    // Wait before ready sense
  localparam int unsigned NSC_WB_CYC  =
    (NSC_WB_NS * NSC_CLK_MHZ + 999) / 1000;
  localparam int unsigned NSC_RDP_NS  = 20000;  // Powerdown recovery time
  localparam int unsigned NSC_RDP_CYC =
    (NSC_RDP_NS * NSC_CLK_MHZ + 999) / 1000;

  // ---------------------------------------------------------------
  // Command codes sent on the link
  // ---------------------------------------------------------------
  localparam logic [7:0] NSC_CMD_ESTAT  = 8'h78;
  localparam logic [7:0] NSC_CMD_PROT   = 8'h7a;
  localparam logic [7:0] NSC_CMD_RESET  = 8'hff;
  localparam logic [7:0] NSC_CMD_DPD    = 8'hb9;
  localparam logic [7:0] NSC_CMD_PARAM  = 8'hec;
  localparam logic [7:0] NSC_CMD_RND1   = 8'h05;
  localparam logic [7:0] NSC_CMD_RND2   = 8'he0;
  localparam logic [7:0] NSC_CMD_STATUS = 8'h70;
  localparam logic [7:0] NSC_CMD_READ   = 8'h00;
  localparam logic [7:0] NSC_PARAM_ADR  = 8'h00;

  // ---------------------------------------------------------------
  // Operation codes written by software
  // ---------------------------------------------------------------
  localparam logic [2:0] NSC_OP_ESTAT = 3'h0;
  localparam logic [2:0] NSC_OP_PROT  = 3'h1;
  localparam logic [2:0] NSC_OP_RESET = 3'h2;
  localparam logic [2:0] NSC_OP_DPD   = 3'h3;
  localparam logic [2:0] NSC_OP_WAKE  = 3'h4;
  localparam logic [2:0] NSC_OP_PARAM = 3'h5;
  localparam logic [2:0] NSC_OP_RND   = 3'h6;

  // Density select
  localparam logic [1:0] NSC_DEN_1G = 2'h0;
  localparam logic [1:0] NSC_DEN_2G = 2'h1;
  localparam logic [1:0] NSC_DEN_4G = 2'h2;

  // ---------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------
  localparam logic [11:0] NSC_REG_CTRL = 12'h000;
  localparam logic [11:0] NSC_REG_ROW  = 12'h004;
  localparam logic [11:0] NSC_REG_STAT = 12'h008;
  localparam logic [11:0] NSC_REG_RES  = 12'h00c;
  localparam logic [11:0] NSC_REG_PGSZ = 12'h010;
  localparam logic [1:0]  NSC_BUF_SEL  = 2'h1;   // adr[11:10] of buffer
  localparam int unsigned NSC_CTRL_START = 3;
  localparam int unsigned NSC_CTRL_DEN   = 4;
  localparam int unsigned NSC_CTRL_OTP   = 6;
  localparam int unsigned NSC_CTRL_WP    = 7;
  localparam int unsigned NSC_CTRL_LEN   = 8;
  localparam logic [15:0] NSC_CTRL_RST   = 16'h0080;
  localparam int unsigned NSC_ST_BUSY   = 0;
  localparam int unsigned NSC_ST_REFUSE = 1;
  localparam int unsigned NSC_ST_DPD    = 2;
  localparam int unsigned NSC_ST_PARAM  = 3;
  localparam int unsigned NSC_ST_UNPROT = 4;
  localparam int unsigned NSC_ST_SOLID  = 5;
  localparam int unsigned NSC_ST_PVALID = 6;
  localparam int unsigned NSC_ST_SPSEEN = 7;
  localparam int unsigned NSC_ST_PG2K   = 8;
  localparam int unsigned NSC_ST_FAIL   = 9;

  // ---------------------------------------------------------------
  // Fields of bytes read back from the device
  // ---------------------------------------------------------------
  localparam int unsigned NSC_SB_FAIL0 = 0;
  localparam int unsigned NSC_SB_FAIL1 = 1;
  localparam int unsigned NSC_SB_RDY   = 6;
  localparam int unsigned NSC_PB_UNPROT = 2;
  localparam logic [1:0]  NSC_PB_SOLID  = 2'h1;
  localparam logic [1:0]  NSC_PB_OPEN   = 2'h2;
  localparam logic [5:0]  NSC_PG_WORD   = 6'h14;  // Bytes 80..83
  localparam logic [31:0] NSC_PG_1G     = 32'h0000_0800;

endpackage

`default_nettype wire

/* verilog/nsc_pbuf.sv */
// Small memory holding parameter bytes read from the device.
// Assumes one write and one registered read per clock, no reset.
`default_nettype none

module nsc_pbuf #(
  parameter int unsigned AW = 8,
  parameter int unsigned DW = 8
) (
  // Clock
  input  wire logic          clk_sys,
  // Write side
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // Read side
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);

  logic [DW-1:0] mem [2**AW];

  // Write port and registered read port
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

`default_nettype wire

/* testbench/nsc_host_checker.sv */
// Port checker for the NAND host controller.
// Assumes it is bound onto nsc_host.
`default_nettype none
module nsc_host_checker (
  // Clock, reset and bus
  input wire logic       clk_sys,
  input wire logic       arst_n,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  // Link
  input wire logic       ce_n,
  input wire logic       cle,
  input wire logic       ale,
  input wire logic       we_n,
  input wire logic       re_n,
  input wire logic       io_oe_n,
  input wire logic [7:0] io_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Strobe stays low for one tick of two clocks
  sequence low_two(s); !s ##1 s; endsequence
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_delay_a: assert property ($rose(wb_ack_o) |->
    $past(wb_cyc_i && wb_stb_i, 2)) else $error("ack without request");
  we_width_a: assert property ($fell(we_n) |=> low_two(we_n))
    else $error("write strobe width");
  re_width_a: assert property ($fell(re_n) |=> low_two(re_n))
    else $error("read strobe width");
  data_hold_a: assert property (!we_n |->
    $stable(io_out) && !io_oe_n && !ce_n) else $error("byte not held");
  latch_excl_a: assert property (!(cle && ale))
    else $error("both latches high");
  read_free_a: assert property (!re_n |->
    io_oe_n && !ce_n && !cle && !ale) else $error("read with drive");
  idle_quiet_a: assert property (ce_n |-> we_n && re_n)
    else $error("strobe while deselected");
endmodule
bind nsc_host nsc_host_checker nsc_host_checker_i (.clk_sys(clk_sys),
  .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
  .re_n(re_n), .io_oe_n(io_oe_n), .io_out(io_out));
`default_nettype wire

/* testbench/nsc_dev_model.sv */
// Behavioural NAND device answering the controller's commands.
// Assumes strobes arrive with ce_n low.
`default_nettype none
module nsc_dev_model (
  // Link from host
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       re_n,
  input  wire logic       wp_n,
  input  wire logic [7:0] io_out,
  // Link to host
  output logic      [7:0] io_in,
  output logic            rb_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  cmd;
  logic [7:0]  a [5];
  logic [11:0] ptr;
  logic        dpd, solid;
  int          na;
  // Power-up state
  initial begin
    io_in = 8'h00;
    rb_n = 1'b1;
    dpd = 1'b0;
    solid = 1'b0;
    cmd = 8'h00;
    ptr = 12'h000;
    na = 0;
  end
  // Latch commands and addresses on the rising write strobe
  always @(posedge we_n) begin
    if (!ce_n && !dpd && cle) begin
      if (rb_n || io_out != 8'hff) cmd = io_out;
      na = 0;
      if (io_out == 8'hb9) dpd = 1'b1;
      if (io_out == 8'hec) ptr = 12'h000;
      if (io_out == 8'he0) ptr = {a[1][3:0], a[0]};
      if (rb_n && (io_out == 8'hff || io_out == 8'hec)) begin
        rb_n = 1'b0;
        rb_n <= #300 1'b1;
      end
    end else if (!ce_n && !dpd && ale && na < 5) begin
      a[na] = io_out;
      na++;
    end
  end
  // Chip enable toggle wakes the device
  always @(negedge ce_n) dpd = 1'b0;
  // Released bus shows the inverse of the last byte
  always @(posedge ce_n) io_in = ~io_in;
  // Present the next byte when the read strobe falls
  always @(negedge re_n) begin
    case (cmd)
      8'h78: io_in = {wp_n, rb_n, rb_n, 4'h0, a[0][6]};
      // Top block bit sets solid protection, kept until power-up
      8'h7a: begin
        solid = solid || a[1][7];
        io_in = {5'h00, a[1][0], solid ? 2'b01 : 2'b10};
      end
      8'h70: io_in = {wp_n, rb_n, rb_n, 5'h00};
      default: begin
        io_in = (ptr[7:2] == 6'h14) ? {4'h0, ptr[1:0] == 2'h1, 3'h0}
                                    : ptr[7:0];
        ptr++;
      end
    endcase
  end
endmodule
`default_nettype wire

/* testbench/nsc_host_test.sv */
// Self-checking bench for the NAND host controller.
// Assumes the device model on the link and a 50 MHz clock.
`default_nettype none
module nsc_host_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, arst_n, we, cyc, stb, ack;
  logic        ce_n, cle, ale, we_n, re_n, wp_n, io_oe_n, rb_n;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [31:0] dat, dat_o, q;
  logic [7:0]  io_out, io_in;
  int          err_total, n_checks;
  nsc_host #(.RDP_CYC(20)) nsc_host_i (.clk_sys(clk_sys), .arst_n(arst_n),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
    .wp_n(wp_n), .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in),
    .rb_n(rb_n));
  nsc_dev_model nsc_dev_model_i (.ce_n(ce_n), .cle(cle), .ale(ale),
    .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_out(io_out),
    .io_in(io_in), .rb_n(rb_n));
  // 50 MHz clock
  initial clk_sys = 1'b0;
  always #10 clk_sys = ~clk_sys;
  // One classic Wishbone cycle
  task automatic wb(input logic [11:0] a, input logic [31:0] d,
                    input logic w, input logic [3:0] s);
    @(posedge clk_sys);
    {adr, dat, sel, we, cyc, stb} <= {a, d, s, w, 2'b11};
    do @(posedge clk_sys); while (ack !== 1'b1);
    q = dat_o;
    {cyc, stb} <= 2'b00;
  endtask
  // Compare one value
  task automatic chk(input string s, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // Read a register and compare the masked field
  task automatic rchk(input string s, input logic [11:0] a,
                      input logic [31:0] m, e);
    wb(a, 32'h0, 1'b0, 4'hf);
    chk(s, e, q & m);
  endtask
  // Start an operation and wait until busy clears
  task automatic op(input logic [31:0] c, r);
    wb(12'h004, r, 1'b1, 4'hf);
    wb(12'h000, c | 32'h88, 1'b1, 4'hf);
    do wb(12'h008, 32'h0, 1'b0, 4'hf); while (q[0] !== 1'b0);
  endtask
  // Verdict
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (40000) @(posedge clk_sys);
    err_total++;
    stop_test;
  end
  // Main sequence
  initial begin
    err_total = 0;
    n_checks = 0;
    arst_n = 1'b0;
    {adr, dat, sel, we, cyc, stb} = '0;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    rchk("ctrl", 12'h000, 32'hffff, 32'h0080);
    rchk("unmapped", 12'h020, 32'hffffffff, 32'h0);
    wb(12'h000, 32'hff8b, 1'b1, 4'h2);
    rchk("lanes", 12'h000, 32'hffff, 32'hff80);
    rchk("nostart", 12'h008, 32'h3, 32'h0);
    op(32'h2, 32'h0);
    op(32'h0, 32'h40);
    rchk("plane1", 12'h00c, 32'hff, 32'he1);
    rchk("fail", 12'h008, 32'h200, 32'h200);
    op(32'h0, 32'h0);
    rchk("plane0", 12'h00c, 32'hff, 32'he0);
    for (int d = 0; d < 3; d++) begin
      op(32'h1 | d << 4, d == 1 ? 32'h0 : 32'h300);
      rchk("prot", 12'h00c, 32'hff, d == 1 ? 32'h2 : 32'h6);
    end
    rchk("pstat", 12'h008, 32'hf0, 32'h50);
    op(32'h1, 32'h8000);
    rchk("solid", 12'h00c, 32'hff, 32'h01);
    rchk("spseen", 12'h008, 32'hf0, 32'he0);
    op(32'h40, 32'h0);
    rchk("otp", 12'h008, 32'h2, 32'h2);
    wb(12'h008, 32'h2, 1'b1, 4'hf);
    wb(12'h000, 32'h8a, 1'b1, 4'hf);
    op(32'h2, 32'h0);
    rchk("rerst", 12'h008, 32'h2, 32'h2);
    wb(12'h008, 32'h2, 1'b1, 4'hf);
    op(32'h405, 32'h0);
    rchk("buf3", 12'h40c, 32'hff, 32'h03);
    op(32'h106, 32'h51);
    rchk("rnd", 12'h544, 32'hff, 32'h08);
    op(32'h5, 32'h0);
    rchk("pgsz", 12'h010, 32'hffffffff, 32'h800);
    rchk("mode", 12'h008, 32'h108, 32'h108);
    rchk("buf255", 12'h7fc, 32'hff, 32'hff);
    op(32'h3, 32'h0);
    rchk("pd", 12'h008, 32'hc, 32'h4);
    op(32'h0, 32'h0);
    rchk("pdref", 12'h008, 32'h6, 32'h6);
    op(32'h4, 32'h0);
    rchk("wake", 12'h008, 32'h4, 32'h0);
    op(32'h0, 32'h40);
    rchk("awake", 12'h00c, 32'hff, 32'he1);
    stop_test;
  end
endmodule
`default_nettype wire
